// [cpe_params.svh]
/*
 Constants of the current and power calculation engine: scaling shifts,
 reset values and serial frame layout.
 Assumes inclusion by bare name from the engine module.
*/
`ifndef CPE_PARAMS_SVH
`define CPE_PARAMS_SVH

// Result scaling, chosen so that each product fits its result width
`define CPE_CUR_SHIFT    15
`define CPE_PWR_SHIFT    8
// Accumulator width: widest result (24) plus log2(1024) plus two guard bits
`define CPE_ACC_W        36
`define CPE_RES_W        24
// Result reset value
`define CPE_RES_RST      24'h000000
// Serial frame: 8 command bits then 16 data bits
`define CPE_CMD_BITS     5'h08
`define CPE_FRAME_BITS   5'h18
// Read selectors carried in the low bits of the command byte
`define CPE_SEL_SHUNT    3'h0
`define CPE_SEL_BUS      3'h1
`define CPE_SEL_TEMP     3'h2
`define CPE_SEL_CUR      3'h3
`define CPE_SEL_PWR      3'h4
`define CPE_SEL_FLAG     3'h5

`endif

// [cpe_pkg.sv]
/*
 Types of the current and power calculation engine.
 Assumes nothing of its surroundings.
*/
package cpe_pkg;
   typedef enum logic [1:0] {
      CPE_IDLE,
      CPE_START,
      CPE_WAIT
   } cpe_state_t;

   typedef enum logic [1:0] {
      CPE_CH_SHUNT,
      CPE_CH_BUS,
      CPE_CH_TEMP
   } cpe_ch_t;
endpackage

// [cpe_engine.sv]
/*
 Current and power engine of a shunt power monitor: converter sequencer,
 background arithmetic, averaging and a read-only serial port.
 Assumes a converter answering each start pulse with one done pulse and
 its sample; all inputs synchronous, serial clock phases >= 2 clocks.
*/
`include "cpe_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cpe_engine (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_arst_n,
   // Configuration
   input  wire logic        i_cfg_wr,
   input  wire logic        i_cfg_cont,
   input  wire logic        i_cfg_shutdown,
   input  wire logic [2:0]  i_cfg_en,
   input  wire logic [2:0]  i_cfg_avg,
   input  wire logic [14:0] i_shunt_cal,
   // Converter
   output logic             o_adc_start,
   output logic [1:0]       o_adc_ch,
   input  wire logic        i_adc_done,
   input  wire logic [15:0] i_adc_data,
   // Results
   output logic [15:0]      o_shunt,
   output logic [15:0]      o_bus,
   output logic [15:0]      o_temp,
   output logic [15:0]      o_current,
   output logic [23:0]      o_power,
   output logic             o_conversion_ready_flag,
   output logic             o_busy,
   // Serial port
   input  wire logic        i_spi_cs_n,
   input  wire logic        i_spi_sclk,
   input  wire logic        i_spi_mosi,
   output logic             o_spi_miso,
   output logic             o_spi_miso_oe
);

   // Reset release through two flops
   logic rst_meta_ff;
   logic rst_n_ff;
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   cpe_pkg::cpe_state_t state_ff;
   cpe_pkg::cpe_state_t nxt_state;
   logic [1:0]  ch_ff;
   logic [1:0]  nxt_ch;
   logic [9:0]  smp_cnt_ff;
   logic        have_shunt_ff;
   logic signed [15:0] shunt_smp_ff;
   logic signed [15:0] cur_ff;
   logic signed [`CPE_ACC_W-1:0] acc_ff  [5];
   logic signed [`CPE_ACC_W-1:0] nxt_acc [5];
   logic signed [`CPE_ACC_W-1:0] add_val [5];
   logic [`CPE_RES_W-1:0] out_ff [5];
   logic        flag_ff;

   // Channel order: shunt, bus, temperature; only enabled ones are taken
   wire       any_en   = |i_cfg_en;
   wire [1:0] first_ch = i_cfg_en[0] ? 2'h0 : (i_cfg_en[1] ? 2'h1 : 2'h2);
   wire [1:0] last_ch  = i_cfg_en[2] ? 2'h2 : (i_cfg_en[1] ? 2'h1 : 2'h0);
   wire [1:0] after_ch = (ch_ff == 2'h0 && i_cfg_en[1]) ? 2'h1 : 2'h2;
   wire       in_wait  = (state_ff == cpe_pkg::CPE_WAIT);
   wire       smp_done = in_wait && i_adc_done;
   wire       pass_end = smp_done && (ch_ff == last_ch);
   wire       start_ok = i_cfg_wr && !i_cfg_shutdown && any_en;

   // Averaging count 1,4,16,64,128,256,512,1024 as a divide shift
   logic [3:0] avg_sh;
   always_comb begin
      case (i_cfg_avg)
         3'h0:    avg_sh = 4'h0;
         3'h1:    avg_sh = 4'h2;
         3'h2:    avg_sh = 4'h4;
         3'h3:    avg_sh = 4'h6;
         3'h4:    avg_sh = 4'h7;
         3'h5:    avg_sh = 4'h8;
         3'h6:    avg_sh = 4'h9;
         default: avg_sh = 4'hA;
      endcase
   end
   wire [10:0] avg_n     = 11'h001 << avg_sh;
   wire        round_end = pass_end && ({1'b0, smp_cnt_ff} == avg_n - 11'h001);

   // Arithmetic beside the sequencer: fires on the bus sample's done pulse
   wire                calc     = smp_done && (ch_ff == 2'h1) && have_shunt_ff;
   wire signed [31:0]  cur_prod = shunt_smp_ff * $signed({1'b0, i_shunt_cal});
   wire signed [15:0]  cur_new  = cur_prod[`CPE_CUR_SHIFT+15:`CPE_CUR_SHIFT];
   wire signed [32:0]  pwr_prod = cur_ff * $signed({1'b0, i_adc_data});
   wire signed [23:0]  pwr_new  = (i_shunt_cal == 15'h0000) ? 24'sh000000
                                : pwr_prod[`CPE_PWR_SHIFT+23:`CPE_PWR_SHIFT];

   // Accumulator inputs: samples on their own done pulse, results on calc
   always_comb begin
      add_val[0] = (smp_done && ch_ff == 2'h0) ? `CPE_ACC_W'(signed'(i_adc_data)) : '0;
      add_val[1] = (smp_done && ch_ff == 2'h1) ? `CPE_ACC_W'({1'b0, i_adc_data}) : '0;
      add_val[2] = (smp_done && ch_ff == 2'h2) ? `CPE_ACC_W'(signed'(i_adc_data)) : '0;
      add_val[3] = calc ? `CPE_ACC_W'(cur_new) : '0;
      add_val[4] = calc ? `CPE_ACC_W'(pwr_new) : '0;
      for (int i = 0; i < 5; i++) begin
         nxt_acc[i] = acc_ff[i] + add_val[i];
      end
   end

   // Sequencer: one converter shared by all inputs
   always_comb begin
      nxt_state = state_ff;
      nxt_ch    = ch_ff;
      case (state_ff)
         cpe_pkg::CPE_IDLE: begin
            nxt_state = cpe_pkg::CPE_IDLE;
         end
         cpe_pkg::CPE_START: begin
            nxt_state = cpe_pkg::CPE_WAIT;
         end
         cpe_pkg::CPE_WAIT: begin
            if (round_end && !i_cfg_cont) begin
               nxt_state = cpe_pkg::CPE_IDLE;
            end else if (pass_end) begin
               nxt_state = cpe_pkg::CPE_START;
               nxt_ch    = first_ch;
            end else if (smp_done) begin
               nxt_state = cpe_pkg::CPE_START;
               nxt_ch    = after_ch;
            end
         end
         default: begin
            nxt_state = cpe_pkg::CPE_IDLE;
         end
      endcase
      // A configuration write restarts the sequence, or stops it in shutdown or with no input enabled
      if (i_cfg_wr) begin
         nxt_state = start_ok ? cpe_pkg::CPE_START : cpe_pkg::CPE_IDLE;
         nxt_ch    = first_ch;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         state_ff <= cpe_pkg::CPE_IDLE;
         ch_ff    <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         ch_ff    <= nxt_ch;
      end
   end

   // Sample counting and per-pass shunt hold
   always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         smp_cnt_ff    <= 10'h000;
         have_shunt_ff <= 1'b0;
         shunt_smp_ff  <= 16'sh0000;
      end else if (i_cfg_wr || round_end) begin
         smp_cnt_ff    <= 10'h000;
         have_shunt_ff <= 1'b0;
      end else begin
         if (pass_end) begin
            smp_cnt_ff    <= smp_cnt_ff + 10'h001;
            have_shunt_ff <= 1'b0;
         end else if (smp_done && ch_ff == 2'h0) begin
            shunt_smp_ff  <= signed'(i_adc_data);
            have_shunt_ff <= 1'b1;
         end
      end
   end

   // Previous current, kept for the next power product
   always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cur_ff <= 16'sh0000;
      end else if (calc) begin
         cur_ff <= cur_new;
      end
   end

   // Accumulators hold intermediates; outputs change only at round end
   always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         for (int i = 0; i < 5; i++) begin
            acc_ff[i] <= '0;
            out_ff[i] <= `CPE_RES_RST;
         end
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (i_cfg_wr || round_end) begin
               acc_ff[i] <= '0;
            end else begin
               acc_ff[i] <= nxt_acc[i];
            end
            if (round_end && !i_cfg_wr) begin
               out_ff[i] <= `CPE_RES_W'(nxt_acc[i] >>> avg_sh);
            end
         end
      end
   end

   // Serial port: synchronous edge detect on the sampled serial clock
   logic       sclk_ff;
   logic [4:0] bit_cnt_ff;
   logic [7:0] cmd_ff;
   logic [15:0] tx_ff;
   wire sclk_rise = i_spi_sclk && !sclk_ff;
   wire sclk_fall = !i_spi_sclk && sclk_ff;
   wire cmd_done  = sclk_rise && (bit_cnt_ff == `CPE_CMD_BITS - 5'h01);
   wire [7:0] cmd_full = {cmd_ff[6:0], i_spi_mosi};
   wire in_data   = (bit_cnt_ff >= `CPE_CMD_BITS);
   wire flag_rd   = cmd_done && (cmd_full[2:0] == `CPE_SEL_FLAG);

   // Read data picked by the command selector
   logic [15:0] rd_data;
   always_comb begin
      case (cmd_full[2:0])
         `CPE_SEL_SHUNT: rd_data = out_ff[0][15:0];
         `CPE_SEL_BUS:   rd_data = out_ff[1][15:0];
         `CPE_SEL_TEMP:  rd_data = out_ff[2][15:0];
         `CPE_SEL_CUR:   rd_data = out_ff[3][15:0];
         `CPE_SEL_PWR:   rd_data = out_ff[4][23:8];
         `CPE_SEL_FLAG:  rd_data = {15'h0000, flag_ff};
         default:        rd_data = 16'h0000;
      endcase
   end

   // Frame counter wraps after each frame, so select may stay low
   always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         sclk_ff    <= 1'b0;
         bit_cnt_ff <= 5'h00;
         cmd_ff     <= 8'h00;
         tx_ff      <= 16'h0000;
      end else begin
         sclk_ff <= i_spi_sclk;
         if (i_spi_cs_n) begin
            bit_cnt_ff <= 5'h00;
         end else if (sclk_rise) begin
            bit_cnt_ff <= (bit_cnt_ff == `CPE_FRAME_BITS - 5'h01) ? 5'h00
                        : bit_cnt_ff + 5'h01;
            if (!in_data) begin
               cmd_ff <= cmd_full;
            end
            if (cmd_done) begin
               tx_ff <= rd_data;
            end
         end else if (sclk_fall && in_data) begin
            tx_ff <= {tx_ff[14:0], 1'b0};
         end
      end
   end

   // Ready flag: a set in the same cycle as a read clear wins; a write blocks the set
   always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         flag_ff <= 1'b0;
      end else if (round_end && !i_cfg_wr) begin
         flag_ff <= 1'b1;
      end else if ((i_cfg_wr && !i_cfg_shutdown) || (flag_rd && !i_spi_cs_n)) begin
         flag_ff <= 1'b0;
      end
   end

   // Output drive
   assign o_adc_start             = (state_ff == cpe_pkg::CPE_START);
   assign o_adc_ch                = ch_ff;
   assign o_shunt                 = out_ff[0][15:0];
   assign o_bus                   = out_ff[1][15:0];
   assign o_temp                  = out_ff[2][15:0];
   assign o_current               = out_ff[3][15:0];
   assign o_power                 = out_ff[4];
   assign o_conversion_ready_flag = flag_ff;
   assign o_busy                  = (state_ff != cpe_pkg::CPE_IDLE);
   assign o_spi_miso              = tx_ff[15];
   assign o_spi_miso_oe           = !i_spi_cs_n; // Drives while selected
endmodule
`default_nettype wire

// [cpe_properties.sv]
/*
 Concurrent checks on the ports of the calculation engine.
 Assumes binding onto cpe_engine with one clock and active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cpe_properties (
   input wire logic        i_clk_sys,
   input wire logic        i_arst_n,
   input wire logic        i_cfg_wr,
   input wire logic        i_cfg_cont,
   input wire logic        i_cfg_shutdown,
   input wire logic [2:0]  i_cfg_en,
   input wire logic [14:0] i_shunt_cal,
   input wire logic        o_adc_start,
   input wire logic [1:0]  o_adc_ch,
   input wire logic        i_adc_done,
   input wire logic [23:0] o_power,
   input wire logic        o_conversion_ready_flag,
   input wire logic        o_busy,
   input wire logic        i_spi_cs_n,
   input wire logic        o_spi_miso_oe
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // Steps of a configuration write and of a continuous pass
   sequence s_cfg_go;
      i_cfg_wr && !i_cfg_shutdown && (|i_cfg_en);
   endsequence
   sequence s_done_cont;
      i_adc_done && o_busy && i_cfg_cont && !i_cfg_wr;
   endsequence
   // Start and channel checks guard the single shared converter
   a_start_single: assert property (o_adc_start && !i_cfg_wr |=> !o_adc_start)
      else $error("start longer than one cycle");
   a_ch_enabled: assert property (o_adc_start |-> o_adc_ch != 2'h3 && i_cfg_en[o_adc_ch])
      else $error("start on a disabled channel");
   a_cont_restart: assert property (s_done_cont |=> o_adc_start)
      else $error("next conversion delayed");
   a_cfg_start: assert property (s_cfg_go |=> o_adc_start && o_busy)
      else $error("write did not start a round");
   a_shdn_refuse: assert property (i_cfg_wr && i_cfg_shutdown |=> !o_adc_start)
      else $error("start in shutdown");
   a_flag_clear: assert property (i_cfg_wr && !i_cfg_shutdown && !i_adc_done
      |=> !o_conversion_ready_flag)
      else $error("flag not cleared by write");
   a_flag_cause: assert property ($rose(o_conversion_ready_flag) |-> $past(i_adc_done))
      else $error("flag rose without a sample");
   a_cal_zero: assert property ($rose(o_conversion_ready_flag) && i_shunt_cal == 15'h0000
      |-> o_power == 24'h000000)
      else $error("power not zero");
   a_oe_select: assert property (o_spi_miso_oe == !i_spi_cs_n)
      else $error("output enable off select");
endmodule
bind cpe_engine cpe_properties u_props (
   .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cfg_wr(i_cfg_wr),
   .i_cfg_cont(i_cfg_cont), .i_cfg_shutdown(i_cfg_shutdown), .i_cfg_en(i_cfg_en),
   .i_shunt_cal(i_shunt_cal), .o_adc_start(o_adc_start), .o_adc_ch(o_adc_ch),
   .i_adc_done(i_adc_done), .o_power(o_power), .o_busy(o_busy),
   .o_conversion_ready_flag(o_conversion_ready_flag), .i_spi_cs_n(i_spi_cs_n),
   .o_spi_miso_oe(o_spi_miso_oe));
`default_nettype wire

// [cpe_spi_host.sv]
/*
 Serial host model: 24-bit read frames, 40 ns clock phases.
 Assumes a system clock of 4 ns; drives only at its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cpe_spi_host (
   input  wire logic i_clk,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_mosi,
   input  wire logic i_miso
);
   localparam int HALF = 10;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end
   // Data bits are read late in the high phase; mosi toggles when unused
   task automatic xfer(input logic [7:0] cmd, input logic keep_low, output logic [15:0] d);
      int i;
      @(negedge i_clk);
      o_cs_n <= 1'b0;
      for (i = 0; i < 24; i++) begin
         o_mosi <= (i < 8) ? cmd[7 - i] : ~o_mosi;
         repeat (HALF) @(negedge i_clk);
         o_sclk <= 1'b1;
         repeat (HALF) @(negedge i_clk);
         if (i >= 7 && i <= 22) d[22 - i] = i_miso;
         o_sclk <= 1'b0;
      end
      repeat (HALF) @(negedge i_clk);
      if (!keep_low) o_cs_n <= 1'b1; // Select may stay low between frames
   endtask
endmodule
`default_nettype wire

// [tb.sv]
/*
 Self-checking bench of the calculation engine with a converter model.
 Assumes the serial host model and the bound property checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb;
   logic        clk = 1'b0, arst_n = 1'b0, cfg_wr = 1'b0, cont = 1'b0, shdn = 1'b0;
   logic [2:0]  en = 3'h3, avg = 3'h0;
   logic [14:0] cal = 15'h7FFF;
   logic        done = 1'b0, start, busy, flag, cs_n, sclk, mosi, miso, oe;
   logic [15:0] data = 16'h0000, shunt, bus, temp, cur;
   logic [1:0]  ch;
   logic [23:0] pwr;
   int          n_fail = 0, n_checks = 0, nsh = 0, cnt = 0;
   always #2 clk = ~clk;
   cpe_engine dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_cfg_wr(cfg_wr), .i_cfg_cont(cont),
      .i_cfg_shutdown(shdn), .i_cfg_en(en), .i_cfg_avg(avg), .i_shunt_cal(cal),
      .o_adc_start(start), .o_adc_ch(ch), .i_adc_done(done), .i_adc_data(data),
      .o_shunt(shunt), .o_bus(bus), .o_temp(temp), .o_current(cur), .o_power(pwr),
      .o_conversion_ready_flag(flag), .o_busy(busy), .i_spi_cs_n(cs_n),
      .i_spi_sclk(sclk), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe));
   cpe_spi_host u_host (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
      .i_miso(miso));
   // Converter: four cycles a sample; a new start drops any sample in flight
   // Shunt count restarts on a write, so each round's samples are known
   always @(negedge clk) begin
      done <= (cnt == 1);
      data <= (cnt != 1) ? ~data : (ch == 2'h0) ? 16'h4000 + 16'(nsh * 4)
         : (ch == 2'h1) ? 16'h0100 : 16'h0C80;
      if (cfg_wr) nsh <= 0;
      else if (cnt == 1 && ch == 2'h0) nsh <= nsh + 1;
      if (start) cnt <= 3;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   task automatic go(input logic [2:0] e, a, input logic c, input logic [14:0] k);
      @(negedge clk);
      {en, avg, cont, cal, cfg_wr} <= {e, a, c, k, 1'b1};
      @(negedge clk);
      cfg_wr <= 1'b0;
   endtask
   task automatic wait_flag;
      for (int i = 0; i < 5000 && flag !== 1'b1; i++) @(negedge clk);
      `CHK(flag, 1'b1)
   endtask
   task automatic s_trig;
      logic [15:0] d;
      go(3'h3, 3'h0, 1'b0, 15'h7FFF);
      wait_flag();
      `CHK(shunt, 16'h4000)
      `CHK(cur, 16'h3FFF)
      `CHK(pwr, 24'h000000)
      go(3'h3, 3'h0, 1'b0, 15'h7FFF);
      wait_flag();
      `CHK(pwr, 24'h003FFF)
      repeat (2) @(negedge clk);
      `CHK(busy, 1'b0)
      u_host.xfer(8'h03, 1'b1, d);
      `CHK(d, 16'h3FFF)
      u_host.xfer(8'h04, 1'b1, d);
      `CHK(d, 16'h003F)
      u_host.xfer(8'h05, 1'b0, d);
      `CHK(d, 16'h0001)
      `CHK(flag, 1'b0)
   endtask
   task automatic s_cal0;
      go(3'h3, 3'h0, 1'b0, 15'h0000);
      wait_flag();
      `CHK(cur, 16'h0000)
      `CHK(pwr, 24'h000000)
   endtask
   // Abort after two shunt samples, then a full round of four
   task automatic s_avg;
      go(3'h7, 3'h1, 1'b0, 15'h7FFF);
      for (int i = 0; i < 2000 && nsh < 2; i++) @(negedge clk);
      `CHK(cur, 16'h0000)
      `CHK(flag, 1'b0)
      go(3'h7, 3'h1, 1'b0, 15'h7FFF);
      wait_flag();
      `CHK(nsh, 4)
      `CHK(shunt, 16'h4006)
      `CHK(cur, 16'h4005)
      `CHK(bus, 16'h0100)
      `CHK(temp, 16'h0C80)
   endtask
   task automatic s_cont;
      int k;
      go(3'h1, 3'h0, 1'b1, 15'h7FFF);
      wait_flag();
      k = nsh;
      repeat (40) @(negedge clk);
      `CHK((nsh - k >= 9 && nsh - k <= 11), 1'b1)
      `CHK(busy, 1'b1)
      {shdn, cfg_wr} <= 2'b11;
      @(negedge clk);
      cfg_wr <= 1'b0;
      repeat (8) @(negedge clk);
      `CHK(busy, 1'b0)
      `CHK(flag, 1'b1)
      shdn <= 1'b0;
   endtask
   // Longest averaging on the shunt input alone
   task automatic s_avg_max;
      go(3'h1, 3'h7, 1'b0, 15'h7FFF);
      wait_flag();
      `CHK(nsh, 1024)
      `CHK(shunt, 16'h47FE)
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_sim();
   end
   initial begin
      repeat (3) @(negedge clk);
      arst_n <= 1'b1;
      repeat (3) @(negedge clk);
      s_trig();
      s_cal0();
      s_avg();
      s_cont();
      s_avg_max();
      end_sim();
   end
endmodule
`default_nettype wire
